// file: verilog/extended_memory_alu_ops.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// (RL1) OR accumulator with memory byte into accumulator or memory; only zero flag changes.
// (RL2) Rotate memory byte left, bit seven into bit zero, flags untouched.
// (RL3) Accumulator rotate forms write accumulator only, flags as memory forms.
// (RL4) Rotate left through carry: carry into bit zero, bit seven into carry.
// (RL5) Rotate right, bit zero into bit seven, flags untouched.
// (RL6) Rotate right through carry: carry into bit seven, bit zero into carry.
// (RL7) Accumulator minus byte minus inverted carry; six arithmetic flags updated.
// (RL8) Accumulator minus byte without borrow; same six flags updated.
// (RL9) After subtraction carry is cleared when negative, set when zero or positive.
// (RL10) Decrement byte, write back, skip when new value is zero; flags untouched.
// (RL11) A taken skip inserts one dummy cycle, making two instruction cycles.
// (RL12) Accumulator forms of decrement and increment skip write accumulator only.
// (RL13) Increment byte, write back, skip when new value is zero; flags untouched.
// (RL14) Set byte writes all ones to memory; flags untouched.
// (RL15) Set bit forces only the selected bit to one; flags untouched.
// (RL16) Skip when byte is nonzero; no flag or data changes.
// (RL17) Swap the two nibbles of the byte in place; flags untouched.
// (RL18) All operands and results are bytes with bit seven most significant.
module extended_memory_alu_ops (
    // Clock and reset.
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    // Instruction request from the decoder.
    input  wire ext_alu_pkg::req_t    req,
    output logic                      req_ready,
    // Direct load of accumulator and flags by the rest of the core.
    input  wire logic                 load_en,
    input  wire logic [7:0]           load_acc,
    input  wire ext_alu_pkg::flags_t  load_flags,
    // Architectural state.
    output logic [7:0]                acc_out,
    output ext_alu_pkg::flags_t       flags_out,
    // Data memory write back.
    output ext_alu_pkg::mem_wr_t      mem_wr,
    // Sequencing towards the fetch logic.
    output logic                      skip_taken,
    output logic                      dummy_cycle,
    output logic                      op_done
);

    // =================================================================
    // State
    typedef struct packed {
        ext_alu_pkg::seq_state_t state;
        logic                    ready;
        logic [7:0]              acc;
        ext_alu_pkg::flags_t     flags;
        ext_alu_pkg::mem_wr_t    mem;
        logic                    skip;
        logic                    dummy;
        logic                    done;
    } state_t;

    state_t cur_reg;
    state_t cur_next;

    // Values of the instruction taken in this cycle.
    logic                take;
    logic [7:0]          operand;
    logic [7:0]          result;
    logic                to_mem;
    logic                to_acc;
    logic                skip_now;
    ext_alu_pkg::flags_t flags_new;

    // Rotator and subtractor hookups.
    logic       rot_left;
    logic       rot_carry;
    logic [7:0] rot_result;
    logic       rot_carry_out;
    logic       sub_borrow;
    logic [7:0] sub_result;
    logic       sub_no_borrow;
    logic       sub_no_half;
    logic       sub_overflow;

    // =================================================================
    // Arithmetic units
    rotate_unit #(
        .WIDTH (ext_alu_pkg::DATA_W)
    ) u_rotate (
        .data_in       (operand),
        .carry_in      (cur_reg.flags.carry_flag),
        .shift_left    (rot_left),
        .through_carry (rot_carry),
        .data_out      (rot_result),
        .carry_out     (rot_carry_out)
    );

    sub_unit #(
        .WIDTH (ext_alu_pkg::DATA_W)
    ) u_sub (
        .minuend        (cur_reg.acc),
        .subtrahend     (operand),
        .borrow_in      (sub_borrow),
        .diff           (sub_result),
        .no_borrow      (sub_no_borrow),
        .no_half_borrow (sub_no_half),
        .overflow       (sub_overflow)
    );

    // =================================================================
    // Operation decode and result selection
    // A request is taken only in the run state with ready shown.
    always_comb begin
        take       = req.valid && cur_reg.ready && (cur_reg.state == ext_alu_pkg::ST_RUN);
        operand    = req.mem_data; // RL18
        result     = operand;
        to_mem     = 1'b0;
        to_acc     = 1'b0;
        skip_now   = 1'b0;
        flags_new  = cur_reg.flags;
        rot_left   = 1'b0;
        rot_carry  = 1'b0;
        sub_borrow = 1'b0;
        case (req.op)
            ext_alu_pkg::OP_OR_TO_ACC, ext_alu_pkg::OP_OR_TO_MEM: begin
                result              = cur_reg.acc | operand; // RL1
                to_acc              = (req.op == ext_alu_pkg::OP_OR_TO_ACC);
                to_mem              = ~to_acc;
                flags_new.zero_flag = (result == ext_alu_pkg::BYTE_ZERO);
            end
            ext_alu_pkg::OP_ROTATE_LEFT, ext_alu_pkg::OP_ROTATE_LEFT_ACC: begin
                rot_left = 1'b1;
                result   = rot_result; // RL2
                to_acc   = (req.op == ext_alu_pkg::OP_ROTATE_LEFT_ACC); // RL3
                to_mem   = ~to_acc;
            end
            ext_alu_pkg::OP_ROTATE_LEFT_CARRY, ext_alu_pkg::OP_ROTATE_LEFT_C_ACC: begin
                rot_left             = 1'b1;
                rot_carry            = 1'b1;
                result               = rot_result;
                flags_new.carry_flag = rot_carry_out; // RL4
                to_acc               = (req.op == ext_alu_pkg::OP_ROTATE_LEFT_C_ACC); // RL3
                to_mem               = ~to_acc;
            end
            ext_alu_pkg::OP_ROTATE_RIGHT, ext_alu_pkg::OP_ROTATE_RIGHT_ACC: begin
                result = rot_result; // RL5
                to_acc = (req.op == ext_alu_pkg::OP_ROTATE_RIGHT_ACC); // RL3
                to_mem = ~to_acc;
            end
            ext_alu_pkg::OP_ROTATE_RIGHT_CARRY, ext_alu_pkg::OP_ROTATE_RIGHT_C_ACC: begin
                rot_carry            = 1'b1;
                result               = rot_result;
                flags_new.carry_flag = rot_carry_out; // RL6
                to_acc               = (req.op == ext_alu_pkg::OP_ROTATE_RIGHT_C_ACC); // RL3
                to_mem               = ~to_acc;
            end
            ext_alu_pkg::OP_SUBTRACT_BORROW, ext_alu_pkg::OP_SUBTRACT_BORROW_M,
            ext_alu_pkg::OP_SUBTRACT_PLAIN, ext_alu_pkg::OP_SUBTRACT_PLAIN_M: begin
                sub_borrow = ((req.op == ext_alu_pkg::OP_SUBTRACT_BORROW)
                           || (req.op == ext_alu_pkg::OP_SUBTRACT_BORROW_M))
                           & ~cur_reg.flags.carry_flag; // RL7
                result     = sub_result; // RL8
                to_mem     = (req.op == ext_alu_pkg::OP_SUBTRACT_BORROW_M)
                          || (req.op == ext_alu_pkg::OP_SUBTRACT_PLAIN_M);
                to_acc     = ~to_mem;
                flags_new.overflow_flag     = sub_overflow;
                flags_new.zero_flag         = (sub_result == ext_alu_pkg::BYTE_ZERO);
                flags_new.half_carry_flag   = sub_no_half;
                flags_new.carry_flag        = sub_no_borrow; // RL9
                flags_new.signed_carry_flag = sub_overflow ^ sub_result[7];
                // With borrow the combined zero keeps a multi-byte zero chain.
                if ((req.op == ext_alu_pkg::OP_SUBTRACT_BORROW)
                    || (req.op == ext_alu_pkg::OP_SUBTRACT_BORROW_M)) begin
                    flags_new.combined_zero_flag = cur_reg.flags.combined_zero_flag
                                                 & flags_new.zero_flag;
                end else begin
                    flags_new.combined_zero_flag = flags_new.zero_flag;
                end
            end
            ext_alu_pkg::OP_DECREMENT_SKIP, ext_alu_pkg::OP_DECREMENT_SKIP_A: begin
                result   = operand - ext_alu_pkg::BYTE_ONE; // RL10
                to_acc   = (req.op == ext_alu_pkg::OP_DECREMENT_SKIP_A); // RL12
                to_mem   = ~to_acc;
                skip_now = (result == ext_alu_pkg::BYTE_ZERO);
            end
            ext_alu_pkg::OP_INCREMENT_SKIP, ext_alu_pkg::OP_INCREMENT_SKIP_A: begin
                result   = operand + ext_alu_pkg::BYTE_ONE; // RL13
                to_acc   = (req.op == ext_alu_pkg::OP_INCREMENT_SKIP_A); // RL12
                to_mem   = ~to_acc;
                skip_now = (result == ext_alu_pkg::BYTE_ZERO);
            end
            ext_alu_pkg::OP_SET_BYTE: begin
                result = ext_alu_pkg::BYTE_ONES; // RL14
                to_mem = 1'b1;
            end
            ext_alu_pkg::OP_SET_BIT: begin
                result = operand | (ext_alu_pkg::BYTE_ONE << req.bit_sel); // RL15
                to_mem = 1'b1;
            end
            ext_alu_pkg::OP_SKIP_NONZERO: begin
                skip_now = (operand != ext_alu_pkg::BYTE_ZERO); // RL16
            end
            ext_alu_pkg::OP_SWAP_NIBBLES: begin
                result = {operand[ext_alu_pkg::NIB_W-1:0], operand[7:ext_alu_pkg::NIB_W]}; // RL17
                to_mem = 1'b1;
            end
            default: begin
                result = operand;
            end
        endcase
    end

    // =================================================================
    // Sequencer and architectural registers
    // A taken skip parks the block for one dummy cycle before done.
    always_comb begin
        cur_next       = cur_reg;
        cur_next.mem.wr = 1'b0;
        cur_next.skip  = 1'b0;
        cur_next.dummy = 1'b0;
        cur_next.done  = 1'b0;
        case (cur_reg.state)
            ext_alu_pkg::ST_DUMMY: begin
                cur_next.state = ext_alu_pkg::ST_RUN;
                cur_next.ready = 1'b1;
                cur_next.done  = 1'b1; // RL11
            end
            default: begin
                if (take) begin
                    cur_next.flags = flags_new;
                    if (to_acc) begin
                        cur_next.acc = result;
                    end
                    cur_next.mem.wr   = to_mem;
                    cur_next.mem.addr = req.addr;
                    cur_next.mem.data = result;
                    if (skip_now) begin
                        cur_next.skip  = 1'b1;
                        cur_next.dummy = 1'b1; // RL11
                        cur_next.ready = 1'b0;
                        cur_next.state = ext_alu_pkg::ST_DUMMY;
                    end else begin
                        cur_next.done = 1'b1;
                    end
                end else if (load_en) begin
                    cur_next.acc   = load_acc;
                    cur_next.flags = load_flags;
                end
            end
        endcase
    end

    // Register the whole state.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur_reg.state     <= ext_alu_pkg::ST_RUN;
            cur_reg.ready     <= 1'b1;
            cur_reg.acc       <= ext_alu_pkg::ACC_RESET;
            cur_reg.flags     <= ext_alu_pkg::FLAGS_RESET;
            cur_reg.mem.wr    <= 1'b0;
            cur_reg.mem.addr  <= ext_alu_pkg::ADDR_RESET;
            cur_reg.mem.data  <= ext_alu_pkg::BYTE_ZERO;
            cur_reg.skip      <= 1'b0;
            cur_reg.dummy     <= 1'b0;
            cur_reg.done      <= 1'b0;
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Outputs come straight from the state register.
    assign req_ready   = cur_reg.ready;
    assign acc_out     = cur_reg.acc;
    assign flags_out   = cur_reg.flags;
    assign mem_wr      = cur_reg.mem;
    assign skip_taken  = cur_reg.skip;
    assign dummy_cycle = cur_reg.dummy;
    assign op_done     = cur_reg.done;

    // =================================================================
    // Checks
    or_result_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL1
        take && (req.op == ext_alu_pkg::OP_OR_TO_MEM) |=>
        mem_wr.wr && (mem_wr.data == ($past(acc_out) | $past(req.mem_data)))
        && (flags_out.carry_flag == $past(flags_out.carry_flag)))
        else $error("OR to memory wrote a wrong byte or touched carry.");

    rotate_left_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL2
        take && (req.op == ext_alu_pkg::OP_ROTATE_LEFT) |=>
        (mem_wr.data == {$past(req.mem_data[6:0]), $past(req.mem_data[7])})
        && $stable(flags_out))
        else $error("Left rotate result or flags wrong.");

    acc_rotate_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL3
        take && (req.op == ext_alu_pkg::OP_ROTATE_RIGHT_ACC) |=>
        !mem_wr.wr && (acc_out == {$past(req.mem_data[0]), $past(req.mem_data[7:1])}))
        else $error("Accumulator rotate wrote memory or gave a wrong value.");

    carry_left_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL4
        take && (req.op == ext_alu_pkg::OP_ROTATE_LEFT_CARRY) |=>
        (flags_out.carry_flag == $past(req.mem_data[7]))
        && (mem_wr.data[0] == $past(flags_out.carry_flag)))
        else $error("Carry did not pass through the left rotate.");

    carry_right_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL6
        take && (req.op == ext_alu_pkg::OP_ROTATE_RIGHT_C_ACC) |=>
        (flags_out.carry_flag == $past(req.mem_data[0]))
        && (acc_out[7] == $past(flags_out.carry_flag)))
        else $error("Carry did not pass through the right rotate.");

    sub_carry_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL9
        take && (req.op == ext_alu_pkg::OP_SUBTRACT_PLAIN) |=>
        (flags_out.carry_flag == ($past(acc_out) >= $past(req.mem_data)))
        && (acc_out == 8'($past(acc_out) - $past(req.mem_data))))
        else $error("Subtraction result or inverted borrow wrong.");

    skip_dummy_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL11
        skip_taken |-> dummy_cycle && !req_ready ##1 op_done && req_ready && !dummy_cycle)
        else $error("Taken skip did not last exactly two cycles.");

    dec_skip_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL10
        take && (req.op == ext_alu_pkg::OP_DECREMENT_SKIP) |=>
        mem_wr.wr && (skip_taken == ($past(req.mem_data) == ext_alu_pkg::BYTE_ONE)))
        else $error("Decrement skip decision wrong.");

    inc_acc_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL12
        take && (req.op == ext_alu_pkg::OP_INCREMENT_SKIP_A) |=>
        !mem_wr.wr && (acc_out == 8'($past(req.mem_data) + 8'h01)))
        else $error("Accumulator increment skip wrote memory or a wrong value.");

    set_bit_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL15
        take && (req.op == ext_alu_pkg::OP_SET_BIT) |=>
        mem_wr.data[$past(req.bit_sel)] && $stable(flags_out))
        else $error("Selected bit was not set.");

    nonzero_skip_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL16
        take && (req.op == ext_alu_pkg::OP_SKIP_NONZERO) |=>
        !mem_wr.wr && $stable(acc_out)
        && (skip_taken == ($past(req.mem_data) != 8'h00)))
        else $error("Skip if nonzero decided wrongly or changed data.");

    swap_nibble_a: assert property (@(posedge sys_clk) disable iff (!reset_n) // RL17
        take && (req.op == ext_alu_pkg::OP_SWAP_NIBBLES) |=>
        (mem_wr.data == {$past(req.mem_data[3:0]), $past(req.mem_data[7:4])}))
        else $error("Nibble swap result wrong.");

endmodule // extended_memory_alu_ops
`default_nettype wire

// file: verilog/ext_alu_pkg.sv
`default_nettype none
// =====================================================================
// Shared types and constants of the extended memory ALU.
package ext_alu_pkg;

    // Datapath widths.
    localparam int DATA_W = 8;
    localparam int ADDR_W = 12;
    localparam int BIT_W  = 3;
    localparam int NIB_W  = 4;

    // Constant operand values and reset values.
    localparam logic [DATA_W-1:0] BYTE_ONES  = 8'hff;
    localparam logic [DATA_W-1:0] BYTE_ONE   = 8'h01;
    localparam logic [DATA_W-1:0] BYTE_ZERO  = 8'h00;
    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;

    // Operation codes presented by the instruction decoder.
    typedef enum logic [4:0] {
        OP_NONE              = 5'h00,
        OP_OR_TO_ACC         = 5'h01,
        OP_OR_TO_MEM         = 5'h02,
        OP_ROTATE_LEFT       = 5'h03,
        OP_ROTATE_LEFT_ACC   = 5'h04,
        OP_ROTATE_LEFT_CARRY = 5'h05,
        OP_ROTATE_LEFT_C_ACC = 5'h06,
        OP_ROTATE_RIGHT      = 5'h07,
        OP_ROTATE_RIGHT_ACC  = 5'h08,
        OP_ROTATE_RIGHT_CARRY= 5'h09,
        OP_ROTATE_RIGHT_C_ACC= 5'h0a,
        OP_SUBTRACT_BORROW   = 5'h0b,
        OP_SUBTRACT_BORROW_M = 5'h0c,
        OP_SUBTRACT_PLAIN    = 5'h0d,
        OP_SUBTRACT_PLAIN_M  = 5'h0e,
        OP_DECREMENT_SKIP    = 5'h0f,
        OP_DECREMENT_SKIP_A  = 5'h10,
        OP_INCREMENT_SKIP    = 5'h11,
        OP_INCREMENT_SKIP_A  = 5'h12,
        OP_SET_BYTE          = 5'h13,
        OP_SET_BIT           = 5'h14,
        OP_SKIP_NONZERO      = 5'h15,
        OP_SWAP_NIBBLES      = 5'h16
    } op_t;

    // Status flags kept by the datapath.
    typedef struct packed {
        logic overflow_flag;
        logic zero_flag;
        logic half_carry_flag;
        logic carry_flag;
        logic signed_carry_flag;
        logic combined_zero_flag;
    } flags_t;

    localparam flags_t FLAGS_RESET = '0;

    // One instruction request with the operand already read from memory.
    typedef struct packed {
        logic              valid;
        op_t               op;
        logic [BIT_W-1:0]  bit_sel;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] mem_data;
    } req_t;

    // Write back towards data memory.
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_wr_t;

    // Sequencer states.
    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_DUMMY = 1'b1
    } seq_state_t;

endpackage
`default_nettype wire

// file: verilog/rotate_unit.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// One-place rotate, plain or through the carry.
module rotate_unit #(
    parameter int WIDTH = 8
) (
    // Operand and carry.
    input  wire logic [WIDTH-1:0] data_in,
    input  wire logic             carry_in,
    // Direction and carry mode.
    input  wire logic             shift_left,
    input  wire logic             through_carry,
    // Result.
    output logic [WIDTH-1:0]      data_out,
    output logic                  carry_out
);

    // The bit leaving one end enters the other end or the carry.
    always_comb begin
        if (shift_left) begin
            data_out  = {data_in[WIDTH-2:0], through_carry ? carry_in : data_in[WIDTH-1]}; // RL2 RL4
            carry_out = data_in[WIDTH-1];
        end else begin
            data_out  = {through_carry ? carry_in : data_in[0], data_in[WIDTH-1:1]}; // RL5 RL6
            carry_out = data_in[0];
        end
    end

endmodule // rotate_unit
`default_nettype wire

// file: verilog/sub_unit.sv
`timescale 1ns/100ps
`default_nettype none
// =====================================================================
// Subtractor giving inverted borrows and signed overflow.
module sub_unit #(
    parameter int WIDTH = 8
) (
    // Operands.
    input  wire logic [WIDTH-1:0] minuend,
    input  wire logic [WIDTH-1:0] subtrahend,
    input  wire logic             borrow_in,
    // Result and raw flags.
    output logic [WIDTH-1:0]      diff,
    output logic                  no_borrow,
    output logic                  no_half_borrow,
    output logic                  overflow
);

    localparam int HALF = WIDTH / 2;

    logic [WIDTH:0] full;
    logic [HALF:0]  low;

    // Carry reads as an inverted borrow, from the whole byte and the low nibble.
    always_comb begin
        full = {1'b0, minuend} - {1'b0, subtrahend} - {{WIDTH{1'b0}}, borrow_in};
        low  = {1'b0, minuend[HALF-1:0]} - {1'b0, subtrahend[HALF-1:0]} - {{HALF{1'b0}}, borrow_in};
        diff           = full[WIDTH-1:0];
        no_borrow      = ~full[WIDTH]; // RL9
        no_half_borrow = ~low[HALF];
        overflow       = (minuend[WIDTH-1] ^ subtrahend[WIDTH-1])
                       & (minuend[WIDTH-1] ^ full[WIDTH-1]);
    end

endmodule // sub_unit
`default_nettype wire

// file: sim/extended_memory_alu_ops_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// Random and corner instructions checked against a byte model.
module extended_memory_alu_ops_tb;
    logic                 sys_clk = 1'b0;
    logic                 reset_n = 1'b0;
    ext_alu_pkg::req_t    req = '0;
    logic                 load_en = 1'b0;
    logic [7:0]           load_acc = 8'h00;
    ext_alu_pkg::flags_t  load_flags = '0;
    logic                 req_ready, skip_taken, dummy_cycle, op_done;
    logic [7:0]           acc_out, m_acc, e_data;
    ext_alu_pkg::flags_t  flags_out, m_fl;
    ext_alu_pkg::mem_wr_t mem_wr;
    logic                 e_wr, e_skip;
    logic [31:0]          rng = 32'h45;
    int                   n_errors = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;
    // Destination masks indexed by operation code.
    localparam logic [22:0] TO_ACC = 23'h052d52;
    localparam logic [22:0] TO_MEM = 23'h5ad2ac;

    extended_memory_alu_ops dut (.sys_clk(sys_clk), .reset_n(reset_n), .req(req), .req_ready(req_ready),
        .load_en(load_en), .load_acc(load_acc), .load_flags(load_flags), .acc_out(acc_out),
        .flags_out(flags_out), .mem_wr(mem_wr), .skip_taken(skip_taken), .dummy_cycle(dummy_cycle),
        .op_done(op_done));

    // Clock and hang guard.
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            wrap_up();
        end
    end

    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic note(input logic ok, input string s);
        samples_checked++;
        if (!ok) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask
    task automatic chk_word(input logic [19:0] g, e);
        note(g === e, "data mismatch");
    endtask
    task automatic chk_flags(input ext_alu_pkg::flags_t g, e);
        note(g === e, "flags mismatch");
    endtask
    task automatic chk_ctl(input logic [3:0] g, e);
        note(g === e, "sequencing mismatch");
    endtask

    // Works out the result, flags, write back and skip of one operation.
    task automatic predict(input logic [4:0] c, input logic [7:0] m, input logic [2:0] b);
        logic [8:0] d;
        logic [4:0] h;
        logic       bi;
        logic       ov;
        logic [7:0] r;
        e_skip = 1'b0;
        r = m;
        case (c)
            5'h01, 5'h02: begin
                r = m_acc | m;
                m_fl.zero_flag = (r == 8'h00);
            end
            5'h03, 5'h04: r = {m[6:0], m[7]};
            5'h05, 5'h06: begin
                r = {m[6:0], m_fl.carry_flag};
                m_fl.carry_flag = m[7];
            end
            5'h07, 5'h08: r = {m[0], m[7:1]};
            5'h09, 5'h0a: begin
                r = {m_fl.carry_flag, m[7:1]};
                m_fl.carry_flag = m[0];
            end
            5'h0b, 5'h0c, 5'h0d, 5'h0e: begin
                bi = (c < 5'h0d) ? ~m_fl.carry_flag : 1'b0;
                d = {1'b0, m_acc} - {1'b0, m} - {8'h00, bi};
                h = {1'b0, m_acc[3:0]} - {1'b0, m[3:0]} - {4'h0, bi};
                r = d[7:0];
                ov = (m_acc[7] ^ m[7]) & (m_acc[7] ^ r[7]);
                m_fl = {ov, r == 8'h00, ~h[4], ~d[8], ov ^ r[7],
                        ((c < 5'h0d) ? m_fl.combined_zero_flag : 1'b1) & (r == 8'h00)};
            end
            5'h0f, 5'h10: r = m - 8'h01;
            5'h11, 5'h12: r = m + 8'h01;
            5'h13: r = 8'hff;
            5'h14: r[b] = 1'b1;
            5'h15: e_skip = (m != 8'h00);
            5'h16: r = {m[3:0], m[7:4]};
            default: ;
        endcase
        if (c >= 5'h0f && c <= 5'h12) e_skip = (r == 8'h00);
        if (TO_ACC[c]) m_acc = r;
        e_wr = TO_MEM[c];
        e_data = r;
    endtask

    // Issues one instruction and checks every result; a skip is also offered a refused request.
    // Results show one cycle after the take; without a skip valid stays up so a following run goes back to back.
    task automatic run(input logic [4:0] c, input logic [7:0] m, input logic [2:0] b);
        logic [11:0] a;
        a = 12'(nxt());
        predict(c, m, b);
        chk_ctl({req_ready, 3'h0}, 4'h8);
        req = '{1'b1, ext_alu_pkg::op_t'(c), b, a, m};
        @(posedge sys_clk);
        #1 chk_word({12'h000, acc_out}, {12'h000, m_acc});
        chk_flags(flags_out, m_fl);
        chk_ctl({mem_wr.wr, skip_taken, dummy_cycle, op_done}, {e_wr, e_skip, e_skip, ~e_skip});
        if (e_wr) chk_word({mem_wr.addr, mem_wr.data}, {a, e_data});
        if (e_skip) begin
            chk_ctl({req_ready, 3'h0}, 4'h0);
            @(posedge sys_clk);
            #1 req.valid = 1'b0;
            chk_ctl({mem_wr.wr, skip_taken, dummy_cycle, op_done}, 4'h1);
            @(posedge sys_clk);
            #1 chk_ctl({mem_wr.wr, skip_taken, dummy_cycle, op_done}, 4'h0);
        end
    endtask

    task automatic load(input logic [7:0] a, input logic [5:0] f);
        req.valid = 1'b0;
        load_en = 1'b1;
        load_acc = a;
        load_flags = f;
        m_acc = a;
        m_fl = f;
        @(posedge sys_clk);
        #1 load_en = 1'b0;
    endtask

    task automatic wrap_up();
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Reset, corner cases, then random instructions.
    initial begin
        repeat (10) @(posedge sys_clk);
        #1 reset_n = 1'b1;
        chk_word({12'h000, acc_out}, {12'h000, ext_alu_pkg::ACC_RESET});
        load(8'h37, 6'h3f);
        run(5'h0d, 8'h37, 3'h0);
        run(5'h0b, 8'h01, 3'h0);
        run(5'h0f, 8'h01, 3'h0);
        run(5'h12, 8'hff, 3'h0);
        run(5'h15, 8'h00, 3'h0);
        for (int c = 0; c < 23; c++) run(5'(c), 8'(nxt()), 3'(nxt()));
        for (int i = 0; i < 400; i++) begin
            if (i % 8 == 0) load(8'(nxt()), 6'(nxt()));
            run(5'(nxt() % 32'h17), 8'(nxt()), 3'(nxt()));
        end
        wrap_up();
    end
endmodule // extended_memory_alu_ops_tb
`default_nettype wire
